/* File: design/ecp_parallel_port_fifo_control.sv */
// ECP parallel port: control registers, shared queue and peripheral handshakes
//
// Operation
// - Control bits 7 and 6 always read one; writes to them are ignored.
// - Direction bit: 0 output, 1 input; modes 000 and 010 always drive.
// - With ack interrupt enable set, rising acknowledge input raises an interrupt.
// - Control bits drive select-in, auto-feed, strobe inverted and initialise unchanged.
// - Mode 010 drains queued bytes to the peripheral with the standard handshake.
// - Mode 011 sends queued bytes forward or receives bytes in reverse.
// - Test mode reads and writes the queue, never handshakes it out.
// - First configuration register always reads 10h.
// - Second configuration: bit7 zero, bit6 interrupt level, bits 2:0 writable.
// - Second configuration bits 5:3 report the assigned interrupt line.
// - Mode field: 000 resets queue, 111 maps the configuration registers.
// - Mode 001 lets direction float data lines; data reads return live lines.
// - Forward ECP: address and data port writes share one queue in order.
// - ECP mode: error mask clear gives interrupt pulse on falling fault.
// - DMA enable clear blocks DMA requests unconditionally.
// - Service bit set blocks DMA and service interrupts; hardware sets it.
// - Service events: terminal count, or free or valid bytes reach threshold.
// - Extended control bit 1 shows full, bit 0 shows empty.
// - All queue ports reach one shared sixteen-byte buffer.
// - Forward: host-ack marks data or command; strobe handshakes with busy.
// - Reverse: peripheral ack clocks bytes; busy level marks data or command.
// - Reverse needs paper-error low; drive only when it allows; select-in off.
// - Mode changes only via 000 or 001; direction changes only in 001.
// - After reset the queue stays disabled until a queue mode is chosen.
`timescale 1ns/1ps

module ecp_parallel_port_fifo_control
	import ecp_port_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [10:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// System side
	input  wire logic [2:0]  irq_resource,
	input  wire logic        dma_tc,
	output logic             dma_req,
	output logic             irq_out,
	// Peripheral pins
	input  wire logic [7:0]  pd_in,
	output logic      [7:0]  pd_out,
	output logic             pd_oe_n,
	output logic             strobe_out,
	output logic             auto_feed_out,
	output logic             initialise_out,
	output logic             select_in_out,
	input  wire logic        peripheral_ack_in,
	input  wire logic        busy_in,
	input  wire logic        paper_error_in,
	input  wire logic        select_status_in,
	input  wire logic        fault_in
);

	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic [7:0]  pd_s;
	logic        ack_s;
	logic        busy_s;
	logic        pe_s;
	logic        sel_s;
	logic        fault_s;
	logic        ack_prev_q;
	logic        fault_prev_q;
	logic        dir_q;
	logic        ack_ie_q;
	logic [3:0]  ctrl_q;
	logic [7:0]  data_q;
	logic [2:0]  mode_q;
	logic        err_mask_q;
	logic        dma_en_q;
	logic        service_q;
	logic [2:0]  cfgb_low_q;
	logic [7:0]  thresh_q;
	logic [8:0]  mem_q [FIFO_DEPTH];
	logic [3:0]  rd_ptr_q;
	logic [3:0]  wr_ptr_q;
	logic [4:0]  count_q;
	logic [4:0]  free_w;
	logic        full_w;
	logic        empty_w;
	logic [8:0]  head_w;
	logic        out_dir;
	logic        fifo_mode;
	logic        bus_wr_fifo;
	logic        bus_rd_fifo;
	logic        hs_push;
	logic        hs_pop;
	logic        push;
	logic        pop;
	logic [8:0]  push_data;
	logic        svc_ev;
	logic        fwd_ok;
	logic        rev_ok;
	hs_state_t   hs_q;
	logic [3:0]  hold_q;
	logic        strobe_hs_q;
	logic        afd_hs_q;
	logic [7:0]  out_byte_q;
	logic        irq_q;
	logic [7:0]  rd_val;
	logic        ecr_wr;
	logic        mode_ok;

	// Every pin input passes two flops before any logic looks at it
	// Reset to the idle pin levels, so the edge detectors see no false edge
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sync1_q <= PINS_IDLE;
			sync2_q <= PINS_IDLE;
		end
		else
		begin
			sync1_q <= {pd_in, peripheral_ack_in, busy_in, paper_error_in,
				select_status_in, fault_in};
			sync2_q <= sync1_q;
		end
	end
	assign {pd_s, ack_s, busy_s, pe_s, sel_s, fault_s} = sync2_q;

	// Queue status and access decode
	assign full_w    = (count_q == FIFO_FULL);
	assign empty_w   = (count_q == 5'h00);
	assign free_w    = FIFO_FULL - count_q;
	assign head_w    = mem_q[rd_ptr_q];
	assign out_dir   = (mode_q == MODE_SPP || mode_q == MODE_COMPAT_FIFO_PORT) ? 1'b0 : dir_q;
	assign fifo_mode = (mode_q == MODE_COMPAT_FIFO_PORT) || (mode_q == MODE_ECP) || (mode_q == MODE_TEST);
	// address and data ports share one queue
	assign bus_wr_fifo = reg_wr && (((reg_addr == OFF_FIFO) && ((mode_q == MODE_COMPAT_FIFO_PORT) ||
		(mode_q == MODE_TEST) || (mode_q == MODE_ECP && !dir_q))) ||
		((reg_addr == OFF_DATA) && mode_q == MODE_ECP && !dir_q));
	assign bus_rd_fifo = reg_rd && (reg_addr == OFF_FIFO) &&
		((mode_q == MODE_TEST) || (mode_q == MODE_ECP && dir_q));
	// ECP handshakes wait for the direction acknowledge; the mode 010 handshake does not
	assign fwd_ok  = (mode_q == MODE_COMPAT_FIFO_PORT) || (mode_q == MODE_ECP && !dir_q && pe_s);
	assign rev_ok  = (mode_q == MODE_ECP) && dir_q && !pe_s;
	assign hs_pop  = (hs_q == HS_IDLE) && fwd_ok && !busy_s;
	assign hs_push = (hs_q == HS_IDLE) && rev_ok && !ack_s;
	// full writes and empty reads do nothing
	assign push    = (bus_wr_fifo || hs_push) && !full_w;
	assign pop     = (bus_rd_fifo || hs_pop) && !empty_w;
	// Tag bit 8 marks a command byte (address port forward, busy low reverse)
	assign push_data = hs_push ? {~busy_s, pd_s} : {reg_addr == OFF_DATA, reg_wdata};

	// one sixteen-byte store for every queue port
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= push_data;
	end

	// Pointers and count; mode 000 holds the queue cleared
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || mode_q == MODE_SPP)
		begin
			rd_ptr_q <= 4'h0;
			wr_ptr_q <= 4'h0;
			count_q  <= 5'h00;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 4'h1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 4'h1;
			if (push && !pop)
				count_q <= count_q + 5'h01;
			else if (pop && !push)
				count_q <= count_q - 5'h01;
		end
	end

	// Control and data registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			dir_q    <= 1'b0;
			ack_ie_q <= 1'b0;
			ctrl_q   <= CTRL_RESET;
			data_q   <= 8'h00;
		end
		else
		begin
			if (reg_wr && reg_addr == OFF_CTRL)
			begin
				ack_ie_q <= reg_wdata[4];
				ctrl_q   <= reg_wdata[3:0];
				// direction only moves in mode 001
				if (mode_q == MODE_PS2)
					dir_q <= reg_wdata[CTRL_DIR_BIT];
			end
			if (reg_wr && reg_addr == OFF_DATA && mode_q != MODE_ECP)
				data_q <= reg_wdata;
		end
	end

	// Extended control, configuration B and thresholds
	assign ecr_wr  = reg_wr && (reg_addr == OFF_ECR);
	assign mode_ok = (mode_q == MODE_SPP) || (mode_q == MODE_PS2) ||
		(reg_wdata[7:5] == MODE_SPP) || (reg_wdata[7:5] == MODE_PS2);
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			mode_q     <= MODE_SPP;
			err_mask_q <= 1'b1;
			dma_en_q   <= 1'b0;
			cfgb_low_q <= CFGB_RESET;
			thresh_q   <= THRESH_RESET;
		end
		else
		begin
			if (ecr_wr)
			begin
				// leave other modes only through 000 or 001
				if (mode_ok)
					mode_q <= reg_wdata[7:5];
				err_mask_q <= reg_wdata[4];
				dma_en_q   <= reg_wdata[3];
			end
			if (reg_wr && reg_addr == OFF_CFGB && mode_q == MODE_CFG)
				cfgb_low_q <= reg_wdata[2:0];
			if (reg_wr && reg_addr == OFF_THRESH)
				thresh_q <= reg_wdata;
		end
	end

	// service events from count or queue level
	assign svc_ev = !service_q && fifo_mode && (dma_en_q ? dma_tc :
		(out_dir ? (count_q >= {1'b0, thresh_q[3:0]}) : (free_w >= {1'b0, thresh_q[7:4]})));

	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			service_q <= 1'b1;
		else if (svc_ev)
			service_q <= 1'b1;
		else if (ecr_wr)
			service_q <= reg_wdata[ECR_SVC_BIT];
	end

	// Interrupt pulses and DMA request; writing service to 1 raises nothing
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ack_prev_q   <= 1'b1;
			fault_prev_q <= 1'b1;
			irq_q        <= 1'b0;
			dma_req      <= 1'b0;
		end
		else
		begin
			ack_prev_q   <= ack_s;
			fault_prev_q <= fault_s;
			// ack rise; fault fall in ECP mode
			irq_q <= (ack_ie_q && ack_s && !ack_prev_q) ||
				(mode_q == MODE_ECP && !err_mask_q && fault_prev_q && !fault_s) || svc_ev;
			// DMA needs enable and clear service flag
			dma_req <= dma_en_q && !service_q && fifo_mode && !svc_ev &&
				(out_dir ? !empty_w : !full_w);
		end
	end
	assign irq_out = irq_q;

	// automatic peripheral handshake for modes 010 and 011
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !(mode_q == MODE_COMPAT_FIFO_PORT || mode_q == MODE_ECP))
		begin
			hs_q        <= HS_IDLE;
			hold_q      <= 4'h0;
			strobe_hs_q <= 1'b1;
			afd_hs_q    <= 1'b1;
			out_byte_q  <= 8'h00;
		end
		else
		begin
			case (hs_q)
				HS_IDLE:
				begin
					// host-ack high for data, low for command
					if (hs_pop && !empty_w)
					begin
						out_byte_q <= head_w[7:0];
						afd_hs_q   <= ~head_w[8];
						hs_q       <= HS_SETUP;
					end
					// latch byte on peripheral ack, answer with host-ack
					else if (hs_push && !full_w)
					begin
						afd_hs_q <= 1'b1;
						hs_q     <= HS_REV_ACK;
					end
					else if (rev_ok)
						afd_hs_q <= 1'b0;
				end
				HS_SETUP:
				begin
					hold_q      <= 4'h0;
					strobe_hs_q <= 1'b0;
					hs_q        <= HS_STROBE;
				end
				HS_STROBE:
				begin
					if (hold_q != STROBE_LAST)
						hold_q <= hold_q + 4'h1;
					// strobe held its least time and busy answered
					else if (busy_s)
					begin
						strobe_hs_q <= 1'b1;
						hs_q        <= HS_RELEASE;
					end
				end
				HS_RELEASE:
				begin
					if (!busy_s)
						hs_q <= HS_IDLE;
				end
				HS_REV_ACK:
				begin
					if (ack_s)
					begin
						afd_hs_q <= 1'b0;
						hs_q     <= HS_IDLE;
					end
				end
				default:
					hs_q <= HS_IDLE;
			endcase
		end
	end

	// Pin outputs, all registered
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			strobe_out     <= 1'b1;
			auto_feed_out  <= 1'b1;
			initialise_out <= CTRL_RESET[2];
			select_in_out  <= 1'b1;
			pd_oe_n        <= 1'b1;
			pd_out         <= 8'h00;
		end
		else
		begin
			strobe_out     <= (mode_q == MODE_COMPAT_FIFO_PORT || mode_q == MODE_ECP) ?
				strobe_hs_q : ~ctrl_q[0];
			auto_feed_out  <= (mode_q == MODE_ECP) ? afd_hs_q : ~ctrl_q[1];
			initialise_out <= ctrl_q[2];
			select_in_out  <= (mode_q == MODE_ECP) ? 1'b1 : ~ctrl_q[3];
			pd_oe_n        <= out_dir || (mode_q == MODE_ECP && !pe_s);
			// test mode shows the head byte only
			if (mode_q == MODE_COMPAT_FIFO_PORT || mode_q == MODE_ECP)
				pd_out <= out_byte_q;
			else if (mode_q == MODE_TEST)
				pd_out <= head_w[7:0];
			else
				pd_out <= data_q;
		end
	end

	// Read value mux; unmapped offsets read zero
	always_comb
	begin
		rd_val = 8'h00;
		case (reg_addr)
			OFF_DATA:   rd_val = (mode_q == MODE_PS2) ? pd_s : data_q;
			OFF_STATUS: rd_val = {~busy_s, ack_s, pe_s, sel_s, fault_s, 3'h7};
			OFF_CTRL:   rd_val = {2'h3, dir_q, ack_ie_q, ctrl_q};
			OFF_FIFO:   rd_val = (mode_q == MODE_CFG) ? CFGA_VALUE :
				(bus_rd_fifo && !empty_w) ? head_w[7:0] : 8'h00;
			OFF_CFGB:   rd_val = (mode_q == MODE_CFG) ?
				{1'b0, irq_q, irq_resource, cfgb_low_q} : 8'h00;
			OFF_ECR:    rd_val = {mode_q, err_mask_q, dma_en_q, service_q, full_w, empty_w};
			OFF_THRESH: rd_val = thresh_q;
			default:    rd_val = 8'h00;
		endcase
	end

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_val : 8'h00;
	end

	// Checks on the behaviour above
	ctrl_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr == OFF_CTRL |=> reg_rdata[7:6] == 2'h3)
		else $error("control top bits not one");
	cfga_value_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr == OFF_FIFO && mode_q == MODE_CFG |=> reg_rdata == 8'h10)
		else $error("configuration A wrong");
	ecr_flags_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr == OFF_ECR |=>
		reg_rdata[1:0] == {$past(count_q) == 5'h10, $past(count_q) == 5'h00})
		else $error("full or empty flag wrong");
	dma_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!dma_en_q || service_q |=> !dma_req)
		else $error("DMA request while blocked");
	mode_guard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ecr_wr && mode_q[2:1] != 2'h0 && reg_wdata[7:6] != 2'h0 |=> $stable(mode_q))
		else $error("illegal mode change taken");
	fifo_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_q == MODE_SPP |=> count_q == 5'h00)
		else $error("queue not held clear");
	full_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		full_w && !pop && mode_q != MODE_SPP |=> full_w && $stable(wr_ptr_q))
		else $error("full queue disturbed");
	drive_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_q == MODE_SPP || mode_q == MODE_COMPAT_FIFO_PORT |=> !pd_oe_n)
		else $error("data lines not driven");
	strobe_min_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(strobe_hs_q) |-> (!strobe_hs_q || hs_q == HS_IDLE || hs_q == HS_SETUP) [*8])
		else $error("strobe pulse too short");
	select_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_q == MODE_ECP |=> select_in_out)
		else $error("select-in asserted in ECP");
	service_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		svc_ev |=> service_q && irq_q)
		else $error("service event lost");

	fwd_byte_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		hs_q == HS_RELEASE ##[1:40] hs_q == HS_IDLE);
	rev_byte_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		hs_push && !full_w);
	service_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		svc_ev && dma_en_q);

endmodule : ecp_parallel_port_fifo_control

/* File: design/ecp_port_pkg.sv */
// Constants, offsets and types for the ECP parallel port controller
package ecp_port_pkg;

	// Register port offsets
	localparam logic [10:0] OFF_DATA   = 11'h000;
	localparam logic [10:0] OFF_STATUS = 11'h001;
	localparam logic [10:0] OFF_CTRL   = 11'h002;
	localparam logic [10:0] OFF_FIFO   = 11'h400;
	localparam logic [10:0] OFF_CFGB   = 11'h401;
	localparam logic [10:0] OFF_ECR    = 11'h402;
	localparam logic [10:0] OFF_THRESH = 11'h403;

	// Mode encodings of the extended control register
	localparam logic [2:0] MODE_SPP   = 3'h0;
	localparam logic [2:0] MODE_PS2   = 3'h1;
	localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
	localparam logic [2:0] MODE_ECP   = 3'h3;
	localparam logic [2:0] MODE_TEST  = 3'h6;
	localparam logic [2:0] MODE_CFG   = 3'h7;

	// Fixed read values and field positions
	localparam logic [7:0] CFGA_VALUE   = 8'h10;
	localparam int         ECR_SVC_BIT  = 2;
	localparam int         CTRL_DIR_BIT = 5;

	// Values after reset
	localparam logic [3:0] CTRL_RESET   = 4'h4;
	localparam logic [2:0] CFGB_RESET   = 3'h7;
	localparam logic [7:0] THRESH_RESET = 8'h88;
	// Synchroniser reset: data 0, ack high, busy low, paper error, select, fault high
	localparam logic [12:0] PINS_IDLE   = 13'h0017;

	// Shared queue geometry
	localparam int         FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_FULL  = 5'h10;

	// Strobe low time: least time, so rounded up to whole cycles
	localparam int         CLK_NS      = 40;
	localparam int         STROBE_NS   = 500;
	localparam logic [3:0] STROBE_CYC  = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] STROBE_LAST = STROBE_CYC - 4'h1;

	// Peripheral handshake states
	typedef enum logic [2:0] {
		HS_IDLE    = 3'b000,
		HS_SETUP   = 3'b001,
		HS_STROBE  = 3'b010,
		HS_RELEASE = 3'b011,
		HS_REV_ACK = 3'b100
	} hs_state_t;

endpackage : ecp_port_pkg

/* File: tb/ecp_parallel_port_fifo_control_tb.sv */
// Self-checking testbench for the ECP parallel port controller
`timescale 1ns/1ps

module ecp_parallel_port_fifo_control_tb
	import ecp_port_pkg::*;
;
	logic        core_clk;
	logic        rst_n;
	logic [10:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [2:0]  irq_resource;
	logic        dma_tc;
	logic        dma_req;
	logic        irq_out;
	logic [7:0]  pd_in;
	logic [7:0]  pd_out;
	logic        pd_oe_n;
	logic        strobe_out;
	logic        auto_feed_out;
	logic        initialise_out;
	logic        select_in_out;
	logic        peripheral_ack_in;
	logic        busy_in;
	logic        paper_error_in;
	logic        fault_in;
	int          miscompares;
	int          tests_run;
	int          irq_cnt;
	int          base;
	int          k;

	ecp_parallel_port_fifo_control dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_resource(irq_resource), .dma_tc(dma_tc),
		.dma_req(dma_req), .irq_out(irq_out), .pd_in(pd_in), .pd_out(pd_out),
		.pd_oe_n(pd_oe_n), .strobe_out(strobe_out), .auto_feed_out(auto_feed_out),
		.initialise_out(initialise_out), .select_in_out(select_in_out),
		.peripheral_ack_in(peripheral_ack_in), .busy_in(busy_in),
		.paper_error_in(paper_error_in), .select_status_in(1'b1), .fault_in(fault_in));

	printer_peer peer (.core_clk(core_clk), .pd_out(pd_out), .pd_oe_n(pd_oe_n),
		.strobe_out(strobe_out), .auto_feed_out(auto_feed_out),
		.initialise_out(initialise_out), .pd_line(pd_in), .ack_q(peripheral_ack_in),
		.busy_q(busy_in), .paper_error_q(paper_error_in));

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	// Interrupt pulses are one cycle wide, so count them as they pass
	always @(posedge core_clk) if (irq_out === 1'b1) irq_cnt++;

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdc(input string what, input logic [10:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(what, {1'b0, reg_rdata}, {1'b0, e});
	endtask : rdc

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle

	// Order: strobe, auto-feed, initialise, select-in
	task automatic pins(input logic [3:0] e);
		check("pins", {5'h0, strobe_out, auto_feed_out, initialise_out, select_in_out}, {5'h0, e});
	endtask : pins

	task automatic wait_got(input int n);
		int w;
		w = 0;
		while (peer.got.size() < n && w < 3000)
		begin
			@(posedge core_clk);
			w++;
		end
		check("bytes sent", 9'(peer.got.size()), 9'(n));
	endtask : wait_got

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge core_clk);
		miscompares++;
		$display("watchdog expired");
		conclude();
	end

	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 11'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		irq_resource = 3'h5;
		dma_tc = 1'b0;
		fault_in = 1'b1;
		miscompares = 0;
		tests_run = 0;
		irq_cnt = 0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		idle(3);
		rdc("control", OFF_CTRL, 8'hc4);
		rdc("ecr", OFF_ECR, 8'h15);
		pins(4'hf);
		check("oe", {8'h0, pd_oe_n}, 9'h000);
		$display("reset values done");
		wr(OFF_CTRL, 8'hff);
		rdc("control", OFF_CTRL, 8'hdf);
		pins(4'h2);
		wr(OFF_CTRL, 8'h00);
		idle(2);
		pins(4'hd);
		wr(OFF_CTRL, 8'h14);
		base = irq_cnt;
		@(posedge core_clk);
		peer.ack_q <= 1'b0;
		idle(4);
		peer.ack_q <= 1'b1;
		idle(6);
		check("ack irq", 9'(irq_cnt - base), 9'h001);
		wr(OFF_CTRL, 8'h04);
		$display("control pins done");
		wr(OFF_ECR, 8'hf4);
		rdc("config a", OFF_FIFO, 8'h10);
		wr(OFF_CFGB, 8'h00);
		for (k = 0; k < 8; k++)
		begin
			irq_resource <= 3'(k);
			rdc("config b", OFF_CFGB, {2'b00, 3'(k), 3'b000});
		end
		wr(OFF_CFGB, 8'h07);
		rdc("config b", OFF_CFGB, 8'h3f);
		rdc("unmapped", 11'h7ff, 8'h00);
		wr(OFF_ECR, 8'h74);
		rdc("ecr", OFF_ECR, 8'hf5);
		wr(OFF_ECR, 8'h14);
		$display("configuration done");
		peer.got.delete();
		wr(OFF_ECR, 8'hd4);
		for (k = 0; k < 17; k++)
			wr(OFF_FIFO, 8'h30 + 8'(k));
		rdc("ecr", OFF_ECR, 8'hd6);
		for (k = 0; k < 16; k++)
			rdc("test queue", OFF_FIFO, 8'h30 + 8'(k));
		rdc("ecr", OFF_ECR, 8'hd5);
		rdc("empty read", OFF_FIFO, 8'h00);
		rdc("ecr", OFF_ECR, 8'hd5);
		check("test strobes", 9'(peer.got.size()), 9'h000);
		base = irq_cnt;
		wr(OFF_ECR, 8'hd8);
		idle(6);
		check("dma req", {8'h0, dma_req}, 9'h001);
		@(posedge core_clk);
		dma_tc <= 1'b1;
		@(posedge core_clk);
		dma_tc <= 1'b0;
		idle(4);
		check("dma req", {8'h0, dma_req}, 9'h000);
		rdc("ecr", OFF_ECR, 8'hdd);
		wr(OFF_ECR, 8'hd0);
		idle(4);
		rdc("ecr", OFF_ECR, 8'hd5);
		wr(OFF_ECR, 8'hd4);
		idle(4);
		check("service irq", 9'(irq_cnt - base), 9'h002);
		wr(OFF_ECR, 8'h14);
		$display("test queue done");
		peer.slow = 1'b1;
		peer.low_min = 999;
		// direction out, strobe and auto-feed idle, then ECP
		wr(OFF_CTRL, 8'h04);
		wr(OFF_ECR, 8'h74);
		wr(OFF_DATA, 8'ha5);
		wr(OFF_FIFO, 8'h3c);
		wr(OFF_FIFO, 8'hc3);
		wait_got(3);
		check("command byte", peer.got[0], 9'h0a5);
		check("data byte", peer.got[1], 9'h13c);
		check("data byte", peer.got[2], 9'h1c3);
		idle(60);
		pins(4'hf);
		wr(OFF_ECR, 8'h64);
		base = irq_cnt;
		@(posedge core_clk);
		fault_in <= 1'b0;
		idle(8);
		check("fault irq", 9'(irq_cnt - base), 9'h001);
		fault_in <= 1'b1;
		wr(OFF_ECR, 8'h74);
		fault_in <= 1'b0;
		idle(8);
		check("masked fault", 9'(irq_cnt - base), 9'h001);
		fault_in <= 1'b1;
		rdc("ecr", OFF_ECR, 8'h75);
		check("strobe width", 9'(peer.low_min >= 13), 9'h001);
		wr(OFF_ECR, 8'h14);
		$display("forward ecp done");
		wr(OFF_ECR, 8'h34);
		wr(OFF_CTRL, 8'h24);
		idle(4);
		check("oe", {8'h0, pd_oe_n}, 9'h001);
		peer.pd_drv <= 8'h81;
		peer.drv <= 1'b1;
		idle(4);
		rdc("live lines", OFF_DATA, 8'h81);
		peer.drv <= 1'b0;
		rdc("control", OFF_CTRL, 8'he4);
		wr(OFF_CTRL, 8'h20);
		wr(OFF_ECR, 8'h74);
		idle(6);
		check("oe", {8'h0, pd_oe_n}, 9'h001);
		peer.send_rev(9'h166);
		peer.send_rev(9'h012);
		idle(4);
		rdc("ecr", OFF_ECR, 8'h74);
		rdc("reverse data", OFF_FIFO, 8'h66);
		rdc("reverse cmd", OFF_FIFO, 8'h12);
		rdc("ecr", OFF_ECR, 8'h75);
		$display("reverse ecp done");
		peer.got.delete();
		peer.slow = 1'b0;
		wr(OFF_ECR, 8'h34);
		wr(OFF_CTRL, 8'h24);
		wr(OFF_ECR, 8'h54);
		idle(4);
		check("oe", {8'h0, pd_oe_n}, 9'h000);
		wr(OFF_FIFO, 8'h5a);
		wr(OFF_FIFO, 8'h0f);
		wait_got(2);
		check("compat byte", {1'b0, peer.got[0][7:0]}, 9'h05a);
		check("compat byte", {1'b0, peer.got[1][7:0]}, 9'h00f);
		check("strobe width", 9'(peer.low_min), 9'(STROBE_CYC));
		$display("compat queue done");
		conclude();
	end
endmodule : ecp_parallel_port_fifo_control_tb

/* File: tb/printer_peer.sv */
// Peripheral model standing on the far side of the parallel port pins
`timescale 1ns/1ps

module printer_peer
(
	// Clock used to pace the model's pin changes
	input  wire logic       core_clk,
	// Host side pins
	input  wire logic [7:0] pd_out,
	input  wire logic       pd_oe_n,
	input  wire logic       strobe_out,
	input  wire logic       auto_feed_out,
	input  wire logic       initialise_out,
	// Peripheral side pins
	output logic      [7:0] pd_line,
	output logic            ack_q,
	output logic            busy_q,
	output logic            paper_error_q
);
	logic [8:0] got[$];
	logic [7:0] pd_drv;
	logic [7:0] pd_last;
	logic       drv;
	logic       slow;
	int         low_n;
	int         low_min;

	// Idle pin levels
	initial
	begin
		ack_q = 1'b1;
		busy_q = 1'b0;
		drv = 1'b0;
		pd_drv = 8'h00;
		pd_last = 8'h00;
		slow = 1'b0;
		low_n = 0;
		low_min = 999;
	end

	// Released lines toggle each cycle, so a stale byte never looks valid
	assign pd_line = !pd_oe_n ? pd_out : (drv ? pd_drv : ~pd_last);
	always @(posedge core_clk) pd_last <= pd_line;

	always @(posedge core_clk) paper_error_q <= initialise_out;

	always
	begin
		@(negedge strobe_out);
		got.push_back({auto_feed_out, pd_out});
		repeat (slow ? 20 : 2) @(posedge core_clk);
		busy_q <= 1'b1;
		wait (strobe_out === 1'b1);
		repeat (slow ? 20 : 2) @(posedge core_clk);
		busy_q <= 1'b0;
	end

	// Shortest strobe low time seen, in clock cycles
	always @(posedge core_clk)
	begin
		if (strobe_out === 1'b0)
			low_n++;
		else
		begin
			if (low_n > 0 && low_n < low_min)
				low_min = low_n;
			low_n = 0;
		end
	end

	task automatic send_rev(input logic [8:0] b);
		int n;
		n = 0;
		@(posedge core_clk);
		pd_drv <= b[7:0];
		drv <= 1'b1;
		busy_q <= b[8];
		repeat (3) @(posedge core_clk);
		ack_q <= 1'b0;
		while (auto_feed_out !== 1'b1 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		ack_q <= 1'b1;
		while (auto_feed_out !== 1'b0 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		drv <= 1'b0;
		busy_q <= 1'b0;
	endtask : send_rev
endmodule : printer_peer
